// >>> rtl/srts_pkg.sv
// alignment-pulse capture block: shared constants, types and register map
// assumes an AXI4-Lite master and one converter sample clock
package srts_pkg;

    // ==========================================================
    // register map: printed offsets are indices, byte = index*4
    localparam logic [11:0] IDX_CTRL  = 12'h120;
    localparam logic [11:0] IDX_IGN   = 12'h121;
    localparam logic [11:0] IDX_DLY   = 12'h123;
    localparam logic [11:0] IDX_STS1  = 12'h128;
    localparam logic [11:0] IDX_PHASE = 12'h129;
    localparam logic [11:0] IDX_CNT   = 12'h12a;
    localparam int          ADDR_W    = 14;

    // ==========================================================
    // field positions and write masks
    localparam int          CTRL_CLR_BIT  = 6;
    localparam int          CTRL_EDGE_BIT = 3;
    localparam int          CTRL_MODE_LO  = 1;
    localparam logic [7:0]  CTRL_WMASK    = 8'h4e;

    // ==========================================================
    // reset values and timing counts
    localparam logic [7:0]  RST_CTRL  = 8'h00;
    localparam logic [3:0]  RST_IGN   = 4'h0;
    localparam logic [6:0]  RST_DLY   = 7'h40;
    localparam logic [3:0]  RST_STS   = 4'h0;
    localparam logic [7:0]  RST_CNT   = 8'h00;
    localparam logic [2:0]  HOLD_WIN  = 3'h4;

    // ==========================================================
    // bus responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ==========================================================
    // capture mode and capture sequencer states (gray path)
    typedef enum logic [1:0] {
        SRTS_MODE_OFF   = 2'h0,
        SRTS_MODE_CONT  = 2'h1,
        SRTS_MODE_NSHOT = 2'h2
    } srts_mode_t;

    typedef enum logic [1:0] {
        SRTS_ST_OFF  = 2'h0,
        SRTS_ST_WAIT = 2'h1,
        SRTS_ST_DONE = 2'h3
    } srts_state_t;

    // ==========================================================
    // AXI4-Lite channel bundles
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } srts_axi_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } srts_axi_rsp_t;

endpackage

// >>> rtl/srts_sync.sv
// alignment-pulse pin synchroniser with selectable sampling clock edge
// assumes the pin is asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none

module srts_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin,
    input  wire logic edge_sel,
    output var  logic level
);

    // ==========================================================
    // first stages
    logic       neg_r;
    logic [2:0] pos_r;
    logic [2:1] negs_r;
    logic       level_r;

    // falling-edge sample, only read by the next stage [R11]
    always_ff @(negedge aclk) begin
        if (!aresetn) neg_r <= 1'b0;
        else          neg_r <= pin;
    end

    // rising-edge chain and the chain behind the falling-edge sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_r  <= 3'h0;
            negs_r <= 2'h0;
        end else begin
            pos_r  <= {pos_r[1:0], pin};
            negs_r <= {negs_r[1], neg_r};
        end
    end

    // ==========================================================
    // a change counts once stages two and three agree
    wire pos_ok = (pos_r[1] == pos_r[2]);
    wire neg_ok = (negs_r[1] == negs_r[2]);

    always_ff @(posedge aclk) begin
        if (!aresetn)                  level_r <= 1'b0;
        else if (edge_sel && neg_ok)   level_r <= negs_r[2]; // R11
        else if (!edge_sel && pos_ok)  level_r <= pos_r[2];  // R11
    end

    assign level = level_r;

endmodule // srts_sync

`default_nettype wire

// >>> rtl/srts_top.sv
// alignment-pulse capture, timestamp delay and status over AXI4-Lite
// assumes one 50 MHz sample clock and a single AXI4-Lite master
//
// Contract
// [R1] n-shot skips the programmed 0..15 leading pulse transitions
// [R2] timestamp comes k sample clocks after capture, k 0..127, reset 0x40
// [R3] read-only hold status in status register bits 7:4, resets zero
// [R4] read-only setup status in status register bits 3:0, resets zero
// [R5] divider phase caught at capture, half input-cycle steps
// [R6] eight-bit event counter counts each captured pulse
// [R7] control bit 6 clears the counter; counter wraps after 255
// [R8] software reads the counter only while mode is disabled
// [R9] mode 00 off, 01 continuous, 10 n-shot; edge change only when off
// [R10] ignore count zero captures the very next transition
// [R11] edge bit picks rising (0) or falling (1) clock edge sampling
// [R12] n-shot captures one transition, then idles until re-armed
// [R13] writes to read-only registers do nothing; reserved bits read zero
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module srts_top (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire srts_pkg::srts_axi_req_t axi_req,
    output var  srts_pkg::srts_axi_rsp_t axi_rsp,
    input  wire logic                    pulse_pin,
    output var  logic                    ts_pulse
);

    // ==========================================================
    // address helpers
    function automatic logic [srts_pkg::ADDR_W-1:0] baddr(
        input logic [11:0] idx
    );
        baddr = {idx, 2'b00};
    endfunction

    function automatic logic addr_hit(
        input logic [srts_pkg::ADDR_W-1:0] a
    );
        addr_hit = (a == baddr(srts_pkg::IDX_CTRL))
                || (a == baddr(srts_pkg::IDX_IGN))
                || (a == baddr(srts_pkg::IDX_DLY))
                || (a == baddr(srts_pkg::IDX_STS1))
                || (a == baddr(srts_pkg::IDX_PHASE))
                || (a == baddr(srts_pkg::IDX_CNT));
    endfunction

    // ==========================================================
    // state
    srts_pkg::srts_axi_rsp_t       rsp_r;
    logic                          aw_full_r;
    logic                          w_full_r;
    logic [srts_pkg::ADDR_W-1:0]   awaddr_r;
    logic [7:0]                    wdata_r;
    logic                          wstrb_r;
    logic [7:0]                    ctrl_r;
    logic [3:0]                    ign_r;
    logic [6:0]                    dly_r;
    logic [3:0]                    setup_r;
    logic [3:0]                    hold_r;
    logic [3:0]                    phase_r;
    logic [7:0]                    cnt_r;
    logic [7:0]                    cnt_nxt;
    logic                          lvl;
    logic                          lvl_d_r;
    logic [3:0]                    hist_r;
    logic [2:0]                    div_r;
    logic [2:0]                    hold_cnt_r;
    logic [3:0]                    skip_r;
    logic [3:0]                    skip_nxt;
    srts_pkg::srts_mode_t          mode_d_r;
    srts_pkg::srts_state_t         st_r;
    srts_pkg::srts_state_t         st_nxt;
    logic                          pend_r;
    logic [6:0]                    dcnt_r;
    logic                          ts_r;

    // ==========================================================
    // pin synchroniser, edge picked by control bit 3
    srts_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin      (pulse_pin),
        .edge_sel (ctrl_r[srts_pkg::CTRL_EDGE_BIT]),
        .level    (lvl)
    );

    // ==========================================================
    // register write decode
    wire write_go = aw_full_r & w_full_r & ~rsp_r.bvalid;
    wire wr_ok    = write_go & wstrb_r;
    wire wr_ctrl  = wr_ok & (awaddr_r == baddr(srts_pkg::IDX_CTRL));
    wire wr_ign   = wr_ok & (awaddr_r == baddr(srts_pkg::IDX_IGN));
    wire wr_dly   = wr_ok & (awaddr_r == baddr(srts_pkg::IDX_DLY));

    // mode and control decode
    wire [1:0] mode_raw = ctrl_r[srts_pkg::CTRL_MODE_LO +: 2];
    wire srts_pkg::srts_mode_t mode = srts_pkg::srts_mode_t'(mode_raw);
    wire cnt_clr  = ctrl_r[srts_pkg::CTRL_CLR_BIT];
    wire is_cont  = (mode == srts_pkg::SRTS_MODE_CONT);   // R9
    wire is_nshot = (mode == srts_pkg::SRTS_MODE_NSHOT);  // R9
    // re-arm on entering n-shot or any rewrite of control or ignore count
    wire arm      = is_nshot & ((mode_d_r != srts_pkg::SRTS_MODE_NSHOT)
                                | wr_ctrl | wr_ign);

    // ==========================================================
    // transition detect and capture decision
    wire trans = lvl & ~lvl_d_r;
    wire nshot_take = is_nshot & ~arm & (st_r == srts_pkg::SRTS_ST_WAIT)
                    & (skip_r == 4'h0);                    // R10 R12
    wire cap   = trans & (is_cont | nshot_take);           // R9

    // ==========================================================
    // n-shot sequencer
    always_comb begin
        st_nxt   = st_r;
        skip_nxt = skip_r;
        case (st_r)
            srts_pkg::SRTS_ST_OFF: begin
                if (arm) begin
                    st_nxt   = srts_pkg::SRTS_ST_WAIT;
                    skip_nxt = ign_r;                      // R1
                end
            end
            srts_pkg::SRTS_ST_WAIT: begin
                if (!is_nshot) begin
                    st_nxt = srts_pkg::SRTS_ST_OFF;
                end else if (arm) begin
                    skip_nxt = ign_r;                      // R1
                end else if (trans && skip_r != 4'h0) begin
                    skip_nxt = skip_r - 4'h1;              // R1
                end else if (trans) begin
                    st_nxt = srts_pkg::SRTS_ST_DONE;       // R12
                end
            end
            srts_pkg::SRTS_ST_DONE: begin
                // later transitions ignored until re-armed
                if (!is_nshot) begin
                    st_nxt = srts_pkg::SRTS_ST_OFF;
                end else if (arm) begin
                    st_nxt   = srts_pkg::SRTS_ST_WAIT;     // R12
                    skip_nxt = ign_r;
                end
            end
            default: begin
                st_nxt = srts_pkg::SRTS_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r     <= srts_pkg::SRTS_ST_OFF;
            skip_r   <= srts_pkg::RST_IGN;
            mode_d_r <= srts_pkg::SRTS_MODE_OFF;
        end else begin
            st_r     <= st_nxt;
            skip_r   <= skip_nxt;
            mode_d_r <= mode;
        end
    end

    // ==========================================================
    // pulse history and internal divider; phase code is the divider
    // count in whole cycles plus the sampling edge as the half step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_d_r <= 1'b0;
            hist_r  <= 4'h0;
            div_r   <= 3'h0;
        end else begin
            lvl_d_r <= lvl;
            hist_r  <= {hist_r[2:0], lvl};
            div_r   <= div_r + 3'h1;
        end
    end

    wire [3:0] phase_now = {div_r, ctrl_r[srts_pkg::CTRL_EDGE_BIT]};

    // status capture: setup is the history before the edge, hold the
    // history a short window after it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            setup_r    <= srts_pkg::RST_STS;
            hold_r     <= srts_pkg::RST_STS;
            phase_r    <= srts_pkg::RST_STS;
            hold_cnt_r <= 3'h0;
        end else if (cap) begin
            setup_r    <= hist_r;                          // R4
            phase_r    <= phase_now;                       // R5
            hold_cnt_r <= srts_pkg::HOLD_WIN;
        end else if (hold_cnt_r != 3'h0) begin
            hold_cnt_r <= hold_cnt_r - 3'h1;
            if (hold_cnt_r == 3'h1) hold_r <= hist_r;      // R3
        end
    end

    // ==========================================================
    // event counter; clear bit held high keeps it at zero
    assign cnt_nxt = cnt_clr ? srts_pkg::RST_CNT                  // R7
                   : cap     ? cnt_r + 8'h01 : cnt_r;             // R6 R7

    always_ff @(posedge aclk) begin
        if (!aresetn) cnt_r <= srts_pkg::RST_CNT;
        else          cnt_r <= cnt_nxt;
    end

    // ==========================================================
    // timestamp delay; a new capture restarts a pending delay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_r <= 1'b0;
            dcnt_r <= 7'h0;
            ts_r   <= 1'b0;
        end else if (cap) begin
            ts_r   <= (dly_r == 7'h0);                     // R2
            pend_r <= (dly_r != 7'h0);
            dcnt_r <= dly_r;
        end else begin
            ts_r   <= pend_r & (dcnt_r == 7'h1);           // R2
            pend_r <= pend_r & (dcnt_r != 7'h1);
            dcnt_r <= pend_r ? dcnt_r - 7'h1 : dcnt_r;
        end
    end

    assign ts_pulse = ts_r;

    // ==========================================================
    // writable registers; read-only ones have no write path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= srts_pkg::RST_CTRL;
            ign_r  <= srts_pkg::RST_IGN;
            dly_r  <= srts_pkg::RST_DLY;
        end else begin
            if (wr_ctrl) ctrl_r <= wdata_r & srts_pkg::CTRL_WMASK;
            if (wr_ign)  ign_r  <= wdata_r[3:0];
            if (wr_dly)  dly_r  <= wdata_r[6:0];           // R2
        end
    end

    // ==========================================================
    // read mux, reserved bits zero
    function automatic logic [31:0] rd_val(
        input logic [srts_pkg::ADDR_W-1:0] a
    );
        rd_val = 32'h0;
        if (a == baddr(srts_pkg::IDX_CTRL))  rd_val[7:0] = ctrl_r;
        if (a == baddr(srts_pkg::IDX_IGN))   rd_val[3:0] = ign_r;
        if (a == baddr(srts_pkg::IDX_DLY))   rd_val[6:0] = dly_r;
        if (a == baddr(srts_pkg::IDX_STS1))  rd_val[7:0] = {hold_r, setup_r};
        if (a == baddr(srts_pkg::IDX_PHASE)) rd_val[3:0] = phase_r;
        if (a == baddr(srts_pkg::IDX_CNT))   rd_val[7:0] = cnt_r;
    endfunction

    // ==========================================================
    // AXI4-Lite write side: address and data taken in either order,
    // response one cycle after both are held
    wire aw_hs = axi_req.awvalid & rsp_r.awready;
    wire w_hs  = axi_req.wvalid & rsp_r.wready;
    wire b_hs  = rsp_r.bvalid & axi_req.bready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= 8'h0;
            wstrb_r       <= 1'b0;
            rsp_r.awready <= 1'b1;
            rsp_r.wready  <= 1'b1;
            rsp_r.bvalid  <= 1'b0;
            rsp_r.bresp   <= srts_pkg::RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_full_r     <= 1'b1;
                awaddr_r      <= axi_req.awaddr;
                rsp_r.awready <= 1'b0;
            end
            if (w_hs) begin
                w_full_r     <= 1'b1;
                wdata_r      <= axi_req.wdata[7:0];
                wstrb_r      <= axi_req.wstrb[0];
                rsp_r.wready <= 1'b0;
            end
            if (write_go) begin
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
                rsp_r.bvalid <= 1'b1;
                rsp_r.bresp  <= addr_hit(awaddr_r) ? srts_pkg::RESP_OKAY
                                                   : srts_pkg::RESP_SLVERR;
            end
            if (b_hs) begin
                rsp_r.bvalid  <= 1'b0;
                rsp_r.awready <= 1'b1;
                rsp_r.wready  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read side: data one cycle after the address is taken
    wire ar_hs = axi_req.arvalid & rsp_r.arready;
    wire r_hs  = rsp_r.rvalid & axi_req.rready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsp_r.arready <= 1'b1;
            rsp_r.rvalid  <= 1'b0;
            rsp_r.rdata   <= 32'h0;
            rsp_r.rresp   <= srts_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            rsp_r.arready <= 1'b0;
            rsp_r.rvalid  <= 1'b1;
            rsp_r.rdata   <= rd_val(axi_req.araddr);       // R13
            rsp_r.rresp   <= addr_hit(axi_req.araddr) ? srts_pkg::RESP_OKAY
                                                      : srts_pkg::RESP_SLVERR;
        end else if (r_hs) begin
            rsp_r.rvalid  <= 1'b0;
            rsp_r.arready <= 1'b1;
        end
    end

    assign axi_rsp = rsp_r;

    // ==========================================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence cap_at_dly1_s;
        cap && dly_r == 7'h1 && !cnt_clr;
    endsequence

    sequence one_late_pulse_s;
        !ts_r ##1 ts_r;
    endsequence

    wire ro_write = wr_ok & ((awaddr_r == baddr(srts_pkg::IDX_STS1))
                          | (awaddr_r == baddr(srts_pkg::IDX_PHASE))
                          | (awaddr_r == baddr(srts_pkg::IDX_CNT)));

    skip_count_a: assert property (                        // R1
        is_nshot && !arm && skip_r != 4'h0 |-> !cap)
        else $error("capture while transitions remain to skip");

    delay_zero_a: assert property (                        // R2
        cap && dly_r == 7'h0 |=> ts_r)
        else $error("zero delay timestamp late");

    delay_one_a: assert property (                         // R2
        cap_at_dly1_s ##1 !cap |-> one_late_pulse_s)
        else $error("one cycle delay timestamp misplaced");

    hold_stat_a: assert property (                         // R3
        cap ##1 !cap[*4] |=> hold_r == $past(hist_r))
        else $error("hold status not caught after window");

    setup_stat_a: assert property (                        // R4
        cap |=> setup_r == $past(hist_r))
        else $error("setup status not caught at capture");

    phase_code_a: assert property (                        // R5
        cap |=> phase_r == $past(phase_now))
        else $error("divider phase not caught at capture");

    count_step_a: assert property (                        // R6
        cap && !cnt_clr |=> cnt_r == $past(cnt_r) + 8'h01)
        else $error("event counter did not step");

    count_clear_a: assert property (                       // R7
        cnt_clr |=> cnt_r == 8'h00)
        else $error("event counter not cleared");

    mode_off_a: assert property (                          // R9
        mode == srts_pkg::SRTS_MODE_OFF |-> !cap)
        else $error("capture while disabled");

    zero_skip_a: assert property (                         // R10
        nshot_take && trans |-> cap)
        else $error("armed zero-skip transition missed");

    nshot_once_a: assert property (                        // R12
        st_r == srts_pkg::SRTS_ST_DONE && !arm |-> !cap)
        else $error("second capture in one n-shot");

    ro_write_a: assert property (                          // R13
        ro_write && !cap && hold_cnt_r == 3'h0 && !cnt_clr
        |=> $stable(cnt_r) && $stable(phase_r) && $stable(setup_r))
        else $error("write changed a read-only register");

endmodule // srts_top

`default_nettype wire

// >>> testbench/srts_pulse_src.sv
// alignment-pulse source model standing in for the clock generator
// assumes widths of three or more aclk cycles high and low
`timescale 1ns/1ps
`default_nettype none

module srts_pulse_src (
    input  wire logic aclk,
    output var  logic pulse_pin
);
    // ====
    // pin idles low; widths vary so prompt and slow sources are seen
    initial pulse_pin = 1'b0;

    task automatic send(input int n, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            pulse_pin <= 1'b1;
            repeat (hi) @(posedge aclk);
            pulse_pin <= 1'b0;
            repeat (lo - 1) @(posedge aclk);
        end
    endtask
endmodule // srts_pulse_src
`default_nettype wire

// >>> testbench/srts_top_tb.sv
// register and pulse-capture bench for the alignment-pulse block
// assumes the pulse source model and the design package are compiled
`timescale 1ns/1ps
`default_nettype none

module srts_top_tb;
    logic                    aclk;
    logic                    aresetn;
    srts_pkg::srts_axi_req_t axi_req;
    srts_pkg::srts_axi_rsp_t axi_rsp;
    wire logic               pulse_pin;
    logic                    ts_pulse;
    int                      n_errors = 0;
    int                      cmp_count = 0;
    int                      cyc = 0;
    int                      ts_n = 0;
    int                      ts_at = 0;
    int                      base;
    int                      l0;
    int                      l1;
    int                      nsk [3] = '{0, 1, 15};
    logic [11:0]             ro [3] = '{srts_pkg::IDX_STS1,
                                        srts_pkg::IDX_PHASE,
                                        srts_pkg::IDX_CNT};

    srts_top DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
                  .axi_rsp(axi_rsp), .pulse_pin(pulse_pin),
                  .ts_pulse(ts_pulse));
    srts_pulse_src SRC (.aclk(aclk), .pulse_pin(pulse_pin));

    // ====
    // clock and timestamp monitor
    initial aclk = 1'b0;
    always #10 aclk = ~aclk;

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (ts_pulse === 1'b1) begin
            ts_n  <= ts_n + 1;
            ts_at <= cyc;
        end
    end

    // ====
    // bus tasks; one cycle idle after each so valids never double-drive
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic wr(input logic [11:0] i, input logic [31:0] d,
                      input logic [1:0] er = 2'h0);
        axi_req.awaddr  <= {i, 2'b00};
        axi_req.wdata   <= d;
        axi_req.wstrb   <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid  <= 1'b1;
        axi_req.bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1); // only the watchdog ends a hang
        axi_req.bready <= 1'b0;
        chk(32'({axi_rsp.bvalid, axi_rsp.bresp}), 32'({1'b1, er}), "wresp");
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] i, input logic [31:0] e,
                      input logic [31:0] m = 32'hffff_ffff,
                      input logic [1:0] er = 2'h0);
        axi_req.araddr  <= {i, 2'b00};
        axi_req.arvalid <= 1'b1;
        axi_req.rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1);
        axi_req.rready <= 1'b0;
        chk(32'({axi_rsp.rvalid, axi_rsp.rresp}), 32'({1'b1, er}), "rresp");
        chk(axi_rsp.rdata & m, e, "rdata");
        @(posedge aclk);
    endtask

    // pin rise to timestamp, in cycles, for one delay setting
    task automatic lat(input logic [6:0] k, output int l);
        int b;
        b = ts_n;
        wr(srts_pkg::IDX_DLY, {25'h0, k});
        wr(srts_pkg::IDX_CTRL, 32'h2);
        l = cyc;
        SRC.send(1, 4, 6);
        repeat (140) @(posedge aclk);
        wr(srts_pkg::IDX_CTRL, 32'h0);
        l = ts_at - l;
        chk(ts_n - b, 1, "one timestamp");
    endtask

    task automatic complete_run;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ====
    // main sequence
    initial begin
        axi_req = '0;
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(srts_pkg::IDX_CTRL, 0);
        rd(srts_pkg::IDX_IGN, 0);
        rd(srts_pkg::IDX_DLY, 32'h40);
        rd(srts_pkg::IDX_STS1, 0);
        rd(srts_pkg::IDX_PHASE, 0);
        rd(srts_pkg::IDX_CNT, 0);
        for (int i = 0; i < 3; i++) begin
            wr(ro[i], 32'hffff_ffff);
            rd(ro[i], 0);
        end
        wr(srts_pkg::IDX_DLY, 32'hffff_ffff);
        rd(srts_pkg::IDX_DLY, 32'h7f);
        wr(srts_pkg::IDX_CTRL, 32'hffff_ffb1);
        rd(srts_pkg::IDX_CTRL, 0);
        wr(12'h122, 1, 2'h2);
        rd(12'h122, 0, 32'hffff_ffff, 2'h2);
        lat(0, l0);
        lat(127, l1);
        chk(l1 - l0, 127, "delay span");
        rd(srts_pkg::IDX_PHASE, 0, 32'hffff_fff1);
        // falling-edge capture; edge changed only while off
        // one-cycle delay here so the single-step timestamp path is exercised
        wr(srts_pkg::IDX_DLY, 1);
        wr(srts_pkg::IDX_CTRL, 32'h8);
        wr(srts_pkg::IDX_CTRL, 32'ha);
        SRC.send(1, 4, 6);
        repeat (20) @(posedge aclk);
        wr(srts_pkg::IDX_CTRL, 32'h8);
        rd(srts_pkg::IDX_PHASE, 1, 32'hffff_fff1);
        // four-cycle pulse: setup history all low, hold history all high
        rd(srts_pkg::IDX_STS1, 32'hf0);
        wr(srts_pkg::IDX_CTRL, 32'h0);
        // counter wrap past 255, then clear
        wr(srts_pkg::IDX_CTRL, 32'h40);
        wr(srts_pkg::IDX_CTRL, 32'h2);
        SRC.send(258, 3, 3);
        repeat (12) @(posedge aclk);
        wr(srts_pkg::IDX_CTRL, 32'h0);
        rd(srts_pkg::IDX_CNT, 2);
        wr(srts_pkg::IDX_CTRL, 32'h40);
        rd(srts_pkg::IDX_CNT, 0);
        // n-shot skip counts at both ends
        foreach (nsk[j]) begin
            wr(srts_pkg::IDX_CTRL, 32'h0);
            wr(srts_pkg::IDX_IGN, 32'(nsk[j]));
            base = ts_n;
            wr(srts_pkg::IDX_CTRL, 32'h4);
            SRC.send(nsk[j], 3, 3);
            repeat (12) @(posedge aclk);
            chk(ts_n - base, 0, "skipped");
            SRC.send(1, 3, 5);
            repeat (12) @(posedge aclk);
            chk(ts_n - base, 1, "captured");
            SRC.send(2, 3, 3);
            repeat (12) @(posedge aclk);
            chk(ts_n - base, 1, "one shot");
            wr(srts_pkg::IDX_CTRL, 32'h0);
            rd(srts_pkg::IDX_CNT, 1);
            wr(srts_pkg::IDX_CTRL, 32'h40);
        end
        complete_run;
    end

    // hang guard, well past the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        complete_run;
    end
endmodule // srts_top_tb
`default_nettype wire
